// *** gac_top.sv ***
// Top: APB register file, ISA side decode and pin multiplexing for the GPIO unit
// Summary of operation
// - Base high nibble reads zero, low twelve bits stored
// - Type 00 asserts on aligned address match
// - Type 01 needs match plus I/O read
// - Type 10 needs match plus I/O write
// - Type 11 needs match plus read or write
// - Level code 3h gives IRQ3, Bh IRQ11
// - Polarity bit set inverts the pin
// - Function bit set selects simple I/O
// - Direction bit set makes a simple I/O pin an input
// - Share bit makes interrupt output shared
// - Qualify bit uses pins as SA[15:12]
// - Control low nibble places fast cycle pin
// - Per-device enables gate the fast cycle signal
// - EPP offsets 3h to 7h covered by bit 4
// - Location codes: odd pins 0-7, even 8-12
// - Simple I/O at base and base plus one
// - Pin does nothing unless globally enabled
`timescale 1ns/1ps
module gac_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [11:0] isa_sa,
  input  wire logic        isa_ior_n,
  input  wire logic        isa_iow_n,
  input  wire logic [7:0]  isa_data_in,
  output logic      [7:0]  isa_data_out,
  output logic             isa_data_oe_n,
  input  wire logic [12:0] gpio_in,
  output logic      [12:0] gpio_out,
  output logic      [12:0] gpio_oe_n,
  output logic             irq3_out,
  output logic             irq3_oe_n,
  output logic             irq11_out,
  output logic             irq11_oe_n,
  input  wire logic [3:0]  unit_access,
  input  wire logic [15:0] parallel_base
);
  localparam int NP = gac_pkg::NUM_PINS;
  localparam int NC = gac_pkg::NUM_CS;

  logic [7:0]    cfg [gac_pkg::NUM_REGS];
  logic [7:0]    reg_idx;
  logic [4:0]    sel_slot;
  logic          mapped;
  logic          access_done;
  logic [11:0]   sa_s;
  logic          ior_n_s;
  logic          iow_n_s;
  logic [7:0]    data_s;
  logic [NP-1:0] pins_s;
  logic          ior;
  logic          iow;
  logic          iow_prev;
  logic [NP-1:0] pin_en;
  logic [NP-1:0] pin_sio;
  logic [NP-1:0] pin_input;
  logic [NP-1:0] pin_pol;
  logic [NP-1:0] pin_val;
  logic [NP-1:0] sio_latch;
  logic [3:0]    high_addr;
  logic [15:0]   isa_addr;
  logic [15:0]   sio_base;
  logic          sio_hit_low;
  logic          sio_hit_high;
  logic [NC-1:0] cs_hit;
  logic [NP-1:0] alt_raw;
  logic [NP-1:0] alt_drive;
  logic [15:0]   epp_offset;
  logic          epp_hit;
  logic          fast_active;
  logic [NP-1:0] fast_pin;
  logic          irq_src;
  logic          irq3_sel;
  logic          irq11_sel;
  logic          irq_shared;
  logic [NP-1:0] next_gpio_out;
  logic [NP-1:0] next_gpio_oe_n;

  function automatic logic [7:0] cfg_at(input logic [7:0] idx);
    return cfg[gac_pkg::slot_of(idx)];
  endfunction

  function automatic logic [15:0] base_of(input logic [7:0] high_idx, input logic [7:0] low_idx);
    return {4'h0, 4'(cfg_at(high_idx)), cfg_at(low_idx)};
  endfunction

  // APB slave: one wait state, unmapped words answer with pslverr
  assign reg_idx     = paddr[9:2];
  assign sel_slot    = gac_pkg::slot_of(reg_idx);
  assign mapped      = (paddr[11:10] == 2'b00) && (sel_slot != gac_pkg::SLOT_NONE);
  assign access_done = psel & penable & pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
      prdata  <= mapped ? {24'h00_0000, cfg[sel_slot]} : 32'h0000_0000;
      pslverr <= ~mapped;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // Masked writes keep reserved and read-only bits at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < gac_pkg::NUM_REGS; i++) begin
        cfg[i] <= gac_pkg::RESET_VALUE;
      end
    end else if (access_done & pwrite & mapped) begin
      cfg[sel_slot] <= pwdata[7:0] & gac_pkg::write_mask(reg_idx);
    end
  end

  // ISA strobes and pins are asynchronous to pclk
  gac_sync #(
    .WIDTH (gac_pkg::SYNC_W)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({isa_sa, isa_ior_n, isa_iow_n, isa_data_in, gpio_in}),
    .q     ({sa_s, ior_n_s, iow_n_s, data_s, pins_s})
  );

  assign ior = ~ior_n_s;
  assign iow = ~iow_n_s;

  // Pin configuration vectors, upper five pins from their own registers
  // Process form so register changes reach through the function
  always_comb begin
    pin_en    = {5'(cfg_at(gac_pkg::IDX_PIN_ENABLE_HIGH)),
                 cfg_at(gac_pkg::IDX_PIN_ENABLE_LOW)};
    pin_sio   = {5'(cfg_at(gac_pkg::IDX_HIGH_FUNCTION)),
                 cfg_at(gac_pkg::IDX_LOW_FUNCTION)};
    pin_input = {5'(cfg_at(gac_pkg::IDX_HIGH_DIRECTION)),
                 cfg_at(gac_pkg::IDX_LOW_DIRECTION)};
    pin_pol   = {5'(cfg_at(gac_pkg::IDX_HIGH_POLARITY)),
                 cfg_at(gac_pkg::IDX_LOW_POLARITY)};
  end
  assign pin_val   = (pins_s ^ pin_pol) & pin_en;

  // High address inputs taken from located pins only when qualification is on
  always_comb begin
    high_addr[0] = |(gac_pkg::loc_to_pins(4'(cfg_at(gac_pkg::IDX_HADDR_SEL_A))) & pin_val);
    high_addr[1] = |(gac_pkg::loc_to_pins(4'(cfg_at(gac_pkg::IDX_HADDR_SEL_A) >> 4)) & pin_val);
    high_addr[2] = |(gac_pkg::loc_to_pins(4'(cfg_at(gac_pkg::IDX_HADDR_SEL_B))) & pin_val);
    high_addr[3] = |(gac_pkg::loc_to_pins(4'(cfg_at(gac_pkg::IDX_HADDR_SEL_B) >> 4)) & pin_val);
    isa_addr     = 1'(cfg_at(gac_pkg::IDX_FAST_CTRL) >> gac_pkg::FAST_QUAL_BIT) ?
                   {high_addr, sa_s} : {4'h0, sa_s};
  end

  // Chip select decoders
  gac_cs_if cs_bus [NC] ();

  for (genvar k = 0; k < NC; k++) begin : g_cs
    localparam logic [7:0] HIGH_IDX = gac_pkg::IDX_CS0_BASE_HIGH + 8'(2 * k);
    localparam logic [7:0] LOW_IDX  = gac_pkg::IDX_CS0_BASE_LOW + 8'(2 * k);
    localparam logic [7:0] CTRL_IDX = gac_pkg::IDX_CHIP_SELECT0_CONTROL + 8'(k);
    assign cs_bus[k].addr = isa_addr;
    always_comb begin
      cs_bus[k].base = base_of(HIGH_IDX, LOW_IDX);
      cs_bus[k].ctrl = cfg_at(CTRL_IDX);
    end
    assign cs_bus[k].ior  = ior;
    assign cs_bus[k].iow  = iow;
    assign cs_hit[k]      = cs_bus[k].hit;
    gac_cs_decode u_dec (
      .bus (cs_bus[k].decoder)
    );
  end

  // Simple I/O port pair
  always_comb begin
    sio_base = base_of(gac_pkg::IDX_SIO_BASE_HIGH, gac_pkg::IDX_SIO_BASE_LOW);
  end
  assign sio_hit_low  = isa_addr == sio_base;
  assign sio_hit_high = isa_addr == 16'(sio_base + gac_pkg::SIO_SECOND);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iow_prev <= 1'b0;
    end else begin
      iow_prev <= iow;
    end
  end

  // Latch once per write strobe so a long strobe writes one value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sio_latch <= '0;
    end else if (iow & ~iow_prev) begin
      if (sio_hit_low) begin
        sio_latch[7:0] <= data_s;
      end
      if (sio_hit_high) begin
        sio_latch[12:8] <= data_s[4:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isa_data_out  <= 8'h00;
      isa_data_oe_n <= 1'b1;
    end else begin
      isa_data_oe_n <= ~(ior & (sio_hit_low | sio_hit_high));
      if (sio_hit_high) begin
        isa_data_out <= {3'h0, pin_val[12:8] & pin_sio[12:8]};
      end else begin
        isa_data_out <= pin_val[7:0] & pin_sio[7:0];
      end
    end
  end

  // Fast cycle: any enabled device hit during a command
  assign epp_offset = isa_addr - parallel_base;
  assign epp_hit    = (epp_offset >= gac_pkg::EPP_OFS_MIN) &&
                      (epp_offset <= gac_pkg::EPP_OFS_MAX);

  always_comb begin
    logic [7:0] dev_en;
    dev_en      = cfg_at(gac_pkg::IDX_FAST_ENABLE);
    fast_active = (ior | iow) &
                  ((dev_en[gac_pkg::DEV_GPIO_BIT] & (sio_hit_low | sio_hit_high | (|cs_hit))) |
                   (dev_en[gac_pkg::DEV_EPP_BIT] & epp_hit) |
                   (|(dev_en[3:0] & unit_access)));
    fast_pin    = gac_pkg::loc_to_pins(4'(cfg_at(gac_pkg::IDX_FAST_CTRL)));
  end

  // Alternate outputs: each strobe lands only on its located pin
  always_comb begin
    alt_raw   = fast_pin & {NP{fast_active}};
    alt_drive = fast_pin;
    for (int k = 0; k < NC; k++) begin
      alt_raw   = alt_raw | (gac_pkg::loc_to_pins(4'(cfg_at(gac_pkg::IDX_CHIP_SELECT0_CONTROL + 8'(k))))
                             & {NP{cs_hit[k]}});
      alt_drive = alt_drive | gac_pkg::loc_to_pins(4'(cfg_at(gac_pkg::IDX_CHIP_SELECT0_CONTROL + 8'(k))));
    end
  end

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      if (pin_sio[p]) begin
        next_gpio_out[p]  = sio_latch[p] ^ pin_pol[p];
        next_gpio_oe_n[p] = ~(pin_en[p] & ~pin_input[p]);
      end else begin
        next_gpio_out[p]  = alt_raw[p] ^ pin_pol[p];
        next_gpio_oe_n[p] = ~(pin_en[p] & alt_drive[p]);
      end
    end
  end

  // Registered pins avoid glitches from the decode cone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_out  <= '0;
      gpio_oe_n <= '1;
    end else begin
      gpio_out  <= next_gpio_out;
      gpio_oe_n <= next_gpio_oe_n;
    end
  end

  // Interrupt mapping from a located alternate-function input pin
  always_comb begin
    irq_src    = |(gac_pkg::loc_to_pins(4'(cfg_at(gac_pkg::IDX_IRQ_LEVEL) >> 4))
                   & pin_val & ~pin_sio);
    irq3_sel   = 4'(cfg_at(gac_pkg::IDX_IRQ_LEVEL)) == gac_pkg::IRQ_CODE_3;
    irq11_sel  = 4'(cfg_at(gac_pkg::IDX_IRQ_LEVEL)) == gac_pkg::IRQ_CODE_11;
    irq_shared = 1'(cfg_at(gac_pkg::IDX_FAST_CTRL) >> gac_pkg::FAST_SHARE_BIT);
  end

  // Shared mode drives only while asserting so other sources can join the line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq3_out   <= 1'b0;
      irq3_oe_n  <= 1'b1;
      irq11_out  <= 1'b0;
      irq11_oe_n <= 1'b1;
    end else begin
      irq3_out   <= irq3_sel & irq_src;
      irq11_out  <= irq11_sel & irq_src;
      irq3_oe_n  <= irq_shared ? ~(irq3_sel & irq_src) : ~irq3_sel;
      irq11_oe_n <= irq_shared ? ~(irq11_sel & irq_src) : ~irq11_sel;
    end
  end

endmodule // gac_top

// *** gac_pkg.sv ***
// Package: register map, field layout and decode helpers for the GPIO alternate function block
package gac_pkg;

  localparam int NUM_PINS = 13;
  localparam int NUM_CS   = 3;
  localparam int NUM_REGS = 24;
  localparam int SYNC_W   = 35;

  localparam logic [7:0] IDX_CS0_BASE_HIGH   = 8'h60;
  localparam logic [7:0] IDX_CS0_BASE_LOW    = 8'h61;
  localparam logic [7:0] IDX_CS1_BASE_HIGH   = 8'h62;
  localparam logic [7:0] IDX_CS1_BASE_LOW    = 8'h63;
  localparam logic [7:0] IDX_CS2_BASE_HIGH   = 8'h64;
  localparam logic [7:0] IDX_CS2_BASE_LOW    = 8'h65;
  localparam logic [7:0] IDX_SIO_BASE_HIGH   = 8'h66;
  localparam logic [7:0] IDX_SIO_BASE_LOW    = 8'h67;
  localparam logic [7:0] IDX_IRQ_LEVEL       = 8'h70;
  localparam logic [7:0] IDX_LOW_POLARITY    = 8'hF0;
  localparam logic [7:0] IDX_CHIP_SELECT0_CONTROL     = 8'hF1;
  localparam logic [7:0] IDX_CHIP_SELECT1_CONTROL     = 8'hF2;
  localparam logic [7:0] IDX_CHIP_SELECT2_CONTROL     = 8'hF3;
  localparam logic [7:0] IDX_LOW_FUNCTION    = 8'hF4;
  localparam logic [7:0] IDX_LOW_DIRECTION   = 8'hF5;
  localparam logic [7:0] IDX_FAST_CTRL       = 8'hF6;
  localparam logic [7:0] IDX_FAST_ENABLE     = 8'hF7;
  localparam logic [7:0] IDX_HIGH_POLARITY   = 8'hF8;
  localparam logic [7:0] IDX_HIGH_FUNCTION   = 8'hF9;
  localparam logic [7:0] IDX_HIGH_DIRECTION  = 8'hFA;
  localparam logic [7:0] IDX_HADDR_SEL_A     = 8'hFB;
  localparam logic [7:0] IDX_HADDR_SEL_B     = 8'hFC;
  localparam logic [7:0] IDX_PIN_ENABLE_LOW  = 8'h25;
  localparam logic [7:0] IDX_PIN_ENABLE_HIGH = 8'h26;

  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] MASK_FULL   = 8'hFF;
  localparam logic [7:0] MASK_NIBBLE = 8'h0F;
  localparam logic [7:0] MASK_FIVE   = 8'h1F;
  localparam logic [7:0] MASK_CTRL   = 8'h3F;
  localparam logic [7:0] MASK_DEVEN  = 8'h9F;
  localparam logic [7:0] MASK_NONE   = 8'h00;
  localparam logic [4:0] SLOT_NONE   = 5'h1F;

  localparam int FAST_SHARE_BIT = 5;
  localparam int FAST_QUAL_BIT  = 4;
  localparam int DEV_GPIO_BIT   = 7;
  localparam int DEV_EPP_BIT    = 4;
  localparam logic [3:0]  IRQ_CODE_3   = 4'h3;
  localparam logic [3:0]  IRQ_CODE_11  = 4'hB;
  localparam logic [15:0] EPP_OFS_MIN  = 16'h0003;
  localparam logic [15:0] EPP_OFS_MAX  = 16'h0007;
  localparam logic [15:0] SIO_SECOND   = 16'h0001;

  typedef enum logic [1:0] {
    CS_KIND_ADDR   = 2'b00,
    CS_KIND_READ   = 2'b01,
    CS_KIND_WRITE  = 2'b10,
    CS_KIND_EITHER = 2'b11
  } gac_cs_kind_type;

  function automatic logic [NUM_PINS-1:0] loc_to_pins(input logic [3:0] code);
    logic [NUM_PINS-1:0] pins;
    pins = '0;
    if (code[0]) begin
      pins[code[3:1]] = 1'b1;
    end else if (code != 4'h0 && code <= 4'hA) begin
      pins[4'h7 + {1'b0, code[3:1]}] = 1'b1;
    end
    return pins;
  endfunction

  function automatic logic [4:0] slot_of(input logic [7:0] idx);
    case (idx)
      IDX_CS0_BASE_HIGH:   return 5'h00;
      IDX_CS0_BASE_LOW:    return 5'h01;
      IDX_CS1_BASE_HIGH:   return 5'h02;
      IDX_CS1_BASE_LOW:    return 5'h03;
      IDX_CS2_BASE_HIGH:   return 5'h04;
      IDX_CS2_BASE_LOW:    return 5'h05;
      IDX_SIO_BASE_HIGH:   return 5'h06;
      IDX_SIO_BASE_LOW:    return 5'h07;
      IDX_IRQ_LEVEL:       return 5'h08;
      IDX_LOW_POLARITY:    return 5'h09;
      IDX_CHIP_SELECT0_CONTROL:     return 5'h0A;
      IDX_CHIP_SELECT1_CONTROL:     return 5'h0B;
      IDX_CHIP_SELECT2_CONTROL:     return 5'h0C;
      IDX_LOW_FUNCTION:    return 5'h0D;
      IDX_LOW_DIRECTION:   return 5'h0E;
      IDX_FAST_CTRL:       return 5'h0F;
      IDX_FAST_ENABLE:     return 5'h10;
      IDX_HIGH_POLARITY:   return 5'h11;
      IDX_HIGH_FUNCTION:   return 5'h12;
      IDX_HIGH_DIRECTION:  return 5'h13;
      IDX_HADDR_SEL_A:     return 5'h14;
      IDX_HADDR_SEL_B:     return 5'h15;
      IDX_PIN_ENABLE_LOW:  return 5'h16;
      IDX_PIN_ENABLE_HIGH: return 5'h17;
      default:             return SLOT_NONE;
    endcase
  endfunction

  function automatic logic [7:0] write_mask(input logic [7:0] idx);
    case (idx)
      IDX_CS0_BASE_HIGH, IDX_CS1_BASE_HIGH,
      IDX_CS2_BASE_HIGH, IDX_SIO_BASE_HIGH:  return MASK_NIBBLE;
      IDX_FAST_CTRL:                         return MASK_CTRL;
      IDX_FAST_ENABLE:                       return MASK_DEVEN;
      IDX_HIGH_POLARITY, IDX_HIGH_FUNCTION,
      IDX_HIGH_DIRECTION, IDX_PIN_ENABLE_HIGH: return MASK_FIVE;
      default: return (slot_of(idx) == SLOT_NONE) ? MASK_NONE : MASK_FULL;
    endcase
  endfunction

endpackage

// *** gac_cs_if.sv ***
// Interface: one chip select decoder's configuration, bus view and hit result
`timescale 1ns/1ps
interface gac_cs_if;
  logic [15:0] addr;
  logic [15:0] base;
  logic [7:0]  ctrl;
  logic        ior;
  logic        iow;
  logic        hit;
  modport owner (output addr, output base, output ctrl, output ior, output iow, input hit);
  modport decoder (input addr, input base, input ctrl, input ior, input iow, output hit);
endinterface

// *** gac_sync.sv ***
// Two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps
module gac_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage;

  always_ff @(posedge clk or negedge rst_n) begin
    // Idle high after reset: strobes are active low, pins pulled up
    if (!rst_n) begin
      stage <= '1;
      q     <= '1;
    end else begin
      stage <= d;
      q     <= stage;
    end
  end
endmodule // gac_sync

// *** gac_cs_decode.sv ***
// Chip select decoder: aligned address match qualified by command type
`timescale 1ns/1ps
module gac_cs_decode (
  gac_cs_if.decoder bus
);
  logic [15:0]              align_mask;
  logic                     addr_match;
  gac_pkg::gac_cs_kind_type kind;

  always_comb begin
    case (bus.ctrl[7:6])
      2'b00:   align_mask = 16'h0000;
      2'b01:   align_mask = 16'h0001;
      2'b10:   align_mask = 16'h0003;
      default: align_mask = 16'h0007;
    endcase
  end

  // Block of 1, 2, 4 or 8 ports
  assign addr_match = ((bus.addr ^ bus.base) & ~align_mask) == 16'h0000;
  assign kind       = gac_pkg::gac_cs_kind_type'(bus.ctrl[5:4]);

  always_comb begin
    case (kind)
      gac_pkg::CS_KIND_ADDR:  bus.hit = addr_match;
      gac_pkg::CS_KIND_READ:  bus.hit = addr_match & bus.ior;
      gac_pkg::CS_KIND_WRITE: bus.hit = addr_match & bus.iow;
      default:                bus.hit = addr_match & (bus.ior | bus.iow);
    endcase
  end
endmodule // gac_cs_decode

// *** gac_isa_host.sv ***
// ISA host model: address, commands and write data toward the block
`timescale 1ns/1ps
module gac_isa_host (
  input  wire logic        pclk,
  output logic      [11:0] sa,
  output logic             ior_n,
  output logic             iow_n,
  output logic      [7:0]  data
);
  initial begin
    sa = 12'h000;
    ior_n = 1'b1;
    iow_n = 1'b1;
    data = 8'h00;
  end
  // Held six edges, above the two the synchroniser needs
  task automatic cycle(input logic [11:0] a, input logic rd, input logic wr, input logic [7:0] d);
    @(posedge pclk);
    sa <= a;
    data <= d;
    ior_n <= !rd;
    iow_n <= !wr;
    repeat (6) @(posedge pclk);
  endtask
  // Released lines flip so a stale value never passes
  task automatic idle();
    @(posedge pclk);
    ior_n <= 1'b1;
    iow_n <= 1'b1;
    sa <= ~sa;
    data <= ~data;
    repeat (4) @(posedge pclk);
  endtask
endmodule // gac_isa_host

// *** gac_top_monitor.sv ***
// Checker: bus answer and pin drive assertions at the top ports
`timescale 1ns/1ps
module gac_top_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        isa_ior_n,
  input wire logic        isa_data_oe_n,
  input wire logic [12:0] gpio_oe_n,
  input wire logic        irq3_oe_n,
  input wire logic        irq11_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic hi_idx;
  assign hi_idx = paddr[9:2] inside {8'h60, 8'h62, 8'h64, 8'h66};
  property p_one_wait;
    $rose(penable) && psel |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("no answer in second access cycle");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_upper_zero;
    pready && !pwrite |-> prdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("read data upper bits set");
  property p_base_high_zero;
    pready && !pwrite && paddr[11:10] == 2'h0 && hi_idx |-> prdata[7:4] == 4'h0;
  endproperty
  a_base_high_zero: assert property (p_base_high_zero) else $error("base high nibble set");
  property p_unmapped;
    pready && !pwrite && paddr[11:10] != 2'h0 |-> pslverr && prdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_irq_one_line;
    !(!irq3_oe_n && !irq11_oe_n);
  endproperty
  a_irq_one_line: assert property (p_irq_one_line) else $error("both interrupt lines driven");
  property p_data_drive;
    !isa_data_oe_n |-> !$past(isa_ior_n, 3);
  endproperty
  a_data_drive: assert property (p_data_drive) else $error("data driven without read");
  property p_reset_idle;
    $rose(presetn) |-> gpio_oe_n == 13'h1FFF;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("pin driven after reset");
  c_write: cover property (pready && pwrite);
  c_refused: cover property (pready && pslverr);
  c_data: cover property (!isa_data_oe_n);
endmodule // gac_top_monitor

bind gac_top gac_top_monitor i_monitor (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .isa_ior_n, .isa_data_oe_n, .gpio_oe_n, .irq3_oe_n, .irq11_oe_n);

// *** gac_top_bench.sv ***
// Testbench: register map over APB and ISA side decode scenarios
`timescale 1ns/1ps
module gac_top_bench;
  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] isa_sa;
  logic        isa_ior_n;
  logic        isa_iow_n;
  logic [7:0]  isa_data_in;
  logic [7:0]  isa_data_out;
  logic        isa_data_oe_n;
  logic [12:0] gpio_in;
  logic [12:0] gpio_out;
  logic [12:0] gpio_oe_n;
  logic        irq3_out;
  logic        irq3_oe_n;
  logic        irq11_out;
  logic        irq11_oe_n;
  logic [3:0]  unit_access;
  logic [15:0] parallel_base;
  logic [31:0] rdata;
  logic        rerr;
  int          failures = 0;
  int          n_compared = 0;
  int          cycles = 0;
  localparam logic [7:0] IDX [17] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67,
    8'h70, 8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF6, 8'hF7};
  localparam logic [7:0] MSK [17] = '{8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h9F};
  localparam int PIN [16] = '{-1, 0, 8, 1, 9, 2, 10, 3, 11, 4, 12, 5, -1, 6, -1, 7};
  localparam logic [3:0] IRQC [5] = '{4'h3, 4'hB, 4'h0, 4'h1, 4'hC};
  localparam logic [3:0] IRQE [5] = '{4'h7, 4'hB, 4'hF, 4'hF, 4'hF};

  gac_top i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .isa_sa, .isa_ior_n, .isa_iow_n, .isa_data_in, .isa_data_out, .isa_data_oe_n,
    .gpio_in, .gpio_out, .gpio_oe_n, .irq3_out, .irq3_oe_n, .irq11_out, .irq11_oe_n,
    .unit_access, .parallel_base);
  gac_isa_host i_host (.pclk(pclk), .sa(isa_sa), .ior_n(isa_ior_n), .iow_n(isa_iow_n),
    .data(isa_data_in));

  always #25 pclk = ~pclk;

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // No fixed latency assumed; only the run timeout ends a wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic w(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {2'h0, idx, 2'h0}, d);
  endtask
  task automatic r(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, {2'h0, idx, 2'h0}, 8'h00);
    chk(rdata, {24'h000000, e});
  endtask
  // Outputs lag inputs by three edges, four through the write latch; look mid-cycle after five
  task automatic settle();
    repeat (5) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic pins(input logic [12:0] g, input logic [3:0] u);
    @(posedge pclk);
    gpio_in <= g;
    unit_access <= u;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    gpio_in = 13'h0000;
    unit_access = 4'h0;
    parallel_base = 16'h0378;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (IDX[i]) begin
      r(IDX[i], 8'h00);
      w(IDX[i], 8'hFF);
      r(IDX[i], MSK[i]);
      w(IDX[i], 8'h00);
    end
    apb(1'b1, 12'h3FC, 8'hFF);
    chk(rerr, 1);
    apb(1'b1, 12'h584, 8'hFF);
    apb(1'b0, 12'h584, 8'h00);
    chk({rerr, rdata[7:0]}, 9'h100);
    r(8'h61, 8'h00);
    w(8'h25, 8'hFF);
    w(8'h26, 8'h1F);
    w(8'h60, 8'h03);
    for (int t = 0; t < 4; t++) begin
      for (int c = 0; c < 3; c++) begin
        w(8'hF1, {2'h0, t[1:0], 4'h1});
        i_host.cycle(12'h300, c == 1, c == 2, 8'h00);
        settle();
        chk({gpio_oe_n[0], gpio_out[0]}, t == 0 || (t[0] && c == 1) || (t[1] && c == 2));
        i_host.idle();
      end
    end
    for (int a = 0; a < 4; a++) begin
      w(8'hF1, {a[1:0], 6'h01});
      i_host.cycle(12'h300 | 12'((1 << a) - 1), 1'b0, 1'b0, 8'h00);
      settle();
      chk(gpio_out[0], 1);
      i_host.cycle(12'h300 + 12'(1 << a), 1'b0, 1'b0, 8'h00);
      settle();
      chk(gpio_out[0], 0);
    end
    w(8'hF0, 8'h01);
    settle();
    chk(gpio_out[0], 1);
    w(8'hF0, 8'h00);
    w(8'hFB, 8'h07);
    w(8'hF6, 8'h10);
    pins(13'h0008, 4'h0);
    i_host.cycle(12'h300, 1'b0, 1'b0, 8'h00);
    settle();
    chk(gpio_out[0], 0);
    pins(13'h0000, 4'h0);
    settle();
    chk(gpio_out[0], 1);
    w(8'hF6, 8'h00);
    w(8'hFB, 8'h00);
    for (int k = 0; k < 16; k++) begin
      w(8'hF1, {4'h0, k[3:0]});
      settle();
      chk(gpio_out, PIN[k] < 0 ? 13'h0000 : 13'h0001 << PIN[k]);
    end
    w(8'hF1, 8'h01);
    w(8'h25, 8'hFE);
    settle();
    chk(gpio_oe_n[0], 1);
    w(8'h25, 8'hFF);
    w(8'hF4, 8'h01);
    w(8'hF5, 8'h01);
    settle();
    chk(gpio_oe_n[0], 1);
    w(8'hF5, 8'h00);
    settle();
    chk({gpio_oe_n[0], gpio_out[0]}, 0);
    w(8'hF1, 8'h00);
    w(8'h66, 8'h02);
    w(8'hF4, 8'hFF);
    w(8'hF0, 8'h0F);
    i_host.cycle(12'h200, 1'b0, 1'b1, 8'hA5);
    i_host.idle();
    settle();
    chk({gpio_oe_n[7:0], gpio_out[7:0]}, 16'h00AA);
    w(8'hF5, 8'hFF);
    w(8'hF9, 8'h1F);
    w(8'hFA, 8'h1F);
    pins(13'h153C, 4'h0);
    i_host.cycle(12'h200, 1'b1, 1'b0, 8'h00);
    settle();
    chk({isa_data_oe_n, isa_data_out}, 9'h033);
    i_host.idle();
    i_host.cycle(12'h201, 1'b1, 1'b0, 8'h00);
    settle();
    chk({isa_data_oe_n, isa_data_out}, 9'h015);
    i_host.idle();
    foreach (IDX[i]) if (IDX[i] > 8'hF3) w(IDX[i], 8'h00);
    w(8'hF0, 8'h00);
    w(8'hF9, 8'h00);
    pins(13'h0002, 4'h0);
    foreach (IRQC[i]) begin
      w(8'h70, {4'h3, IRQC[i]});
      settle();
      chk({irq3_oe_n, irq11_oe_n, irq3_oe_n | irq3_out, irq11_oe_n | irq11_out}, IRQE[i]);
    end
    w(8'h70, 8'h33);
    w(8'hF6, 8'h20);
    settle();
    chk(irq3_oe_n, 0);
    pins(13'h0000, 4'h0);
    settle();
    chk(irq3_oe_n, 1);
    w(8'hF6, 8'h05);
    settle();
    chk({irq3_oe_n, irq3_out}, 0);
    w(8'h70, 8'h00);
    i_host.cycle(12'h100, 1'b1, 1'b0, 8'h00);
    for (int k = 0; k < 4; k++) begin
      pins(13'h0000, 4'(1 << k));
      w(8'hF7, 8'h00);
      settle();
      chk(gpio_out[2], 0);
      w(8'hF7, 8'(1 << k));
      settle();
      chk(gpio_out[2], 1);
    end
    pins(13'h0000, 4'h0);
    w(8'hF7, 8'h10);
    i_host.cycle(12'h37B, 1'b1, 1'b0, 8'h00);
    settle();
    chk(gpio_out[2], 1);
    i_host.cycle(12'h37A, 1'b1, 1'b0, 8'h00);
    settle();
    chk(gpio_out[2], 0);
    w(8'hF1, 8'h30);
    w(8'hF7, 8'h80);
    i_host.cycle(12'h300, 1'b1, 1'b0, 8'h00);
    settle();
    chk(gpio_out[2], 1);
    i_host.idle();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    r(8'hF7, 8'h00);
    r(8'hF1, 8'h00);
    final_report();
  end
endmodule // gac_top_bench
